// ---- pkg/asb_consts.svh ----
// offsets, field positions, reset values and vectors of the status core
`ifndef ASB_CONSTS_SVH
`define ASB_CONSTS_SVH
// register byte offsets
`define ASB_OFF_STATUS 8'h00
`define ASB_OFF_OP 8'h04
`define ASB_OFF_ACC 8'h08
`define ASB_OFF_FREG 8'h0C
`define ASB_OFF_PC 8'h10
`define ASB_OFF_BANK 8'h14
// status bit positions
`define ASB_B_IRP 7
`define ASB_B_RP1 6
`define ASB_B_RP0 5
`define ASB_B_TO 4
`define ASB_B_PD 3
`define ASB_B_Z 2
`define ASB_B_DC 1
`define ASB_B_C 0
// status reset value and write masks
`define ASB_STATUS_RST 8'h18
`define ASB_WR_MASK 8'hE7
`define ASB_CLR_MASK 8'hE0
// operation word fields
`define ASB_OPF_DEST 4
`define ASB_OPF_FSTAT 5
`define ASB_OPF_LIT_LSB 8
// program counter word fields
`define ASB_PCF_JUMP 16
`define ASB_PCF_STEP 17
`define ASB_PCF_IRQ 18
// program space and vectors
`define ASB_PC_W 13
`define ASB_PROG_WORDS 8192
`define ASB_RESET_VEC 13'h0000
`define ASB_IRQ_VEC 13'h0004
// bus responses
`define ASB_RESP_OKAY 2'h0
`define ASB_RESP_SLVERR 2'h2
`endif

// ---- pkg/asb_pkg.sv ----
// operation codes of the status core
package asb_pkg;
  typedef enum logic [3:0] {
    nop_op = 4'h0,
    add_acc_to_reg_op = 4'h1,
    add_literal_op = 4'h2,
    literal_minus_acc_op = 4'h3,
    reg_minus_acc_op = 4'h4,
    rotate_right_op = 4'h5,
    rotate_left_op = 4'h6,
    clear_reg_op = 4'h7,
    bit_clear_op = 4'h8,
    bit_set_op = 4'h9,
    nibble_exchange_op = 4'hA,
    store_acc_op = 4'hB,
    and_literal_op = 4'hC,
    wdog_clear_op = 4'hD,
    sleep_op = 4'hE
  } asb_op_e;
endpackage

// ---- logic/asb_flag_alu.sv ----
// arithmetic unit producing a result and the zero, nibble carry and carry flags
`timescale 1ns/1ps
module asb_flag_alu (
  // operation select
  input asb_pkg::asb_op_e op,
  // operands
  input logic [7:0] f_val,
  input logic [7:0] w_val,
  input logic [7:0] lit,
  input logic c_in,
  // result and flags
  output logic [7:0] res,
  output logic z,
  output logic dc,
  output logic c,
  output logic upd_z,
  output logic upd_dc,
  output logic upd_c
);
  logic use_lit;
  logic is_sub;
  logic is_arith;
  logic is_rot;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [7:0] bit_mask;
  logic [8:0] sum;
  logic [4:0] nib;

  // operand selection, subtraction adds the two's complement of the accumulator
  assign use_lit = op == asb_pkg::add_literal_op || op == asb_pkg::literal_minus_acc_op;
  assign is_sub = op == asb_pkg::literal_minus_acc_op || op == asb_pkg::reg_minus_acc_op;
  assign is_arith = is_sub || op == asb_pkg::add_acc_to_reg_op
    || op == asb_pkg::add_literal_op;
  assign is_rot = op == asb_pkg::rotate_right_op || op == asb_pkg::rotate_left_op;
  assign opa = use_lit ? lit : f_val;
  assign opb = is_sub ? ~w_val : w_val;
  assign sum = {1'b0, opa} + {1'b0, opb} + {8'h00, is_sub};
  assign nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, is_sub};
  assign bit_mask = 8'h01 << lit[2:0];

  // result per operation
  always_comb
  begin
    case (op)
      asb_pkg::add_acc_to_reg_op,
      asb_pkg::add_literal_op,
      asb_pkg::literal_minus_acc_op,
      asb_pkg::reg_minus_acc_op: res = sum[7:0];
      asb_pkg::rotate_right_op: res = {c_in, f_val[7:1]};
      asb_pkg::rotate_left_op: res = {f_val[6:0], c_in};
      asb_pkg::clear_reg_op: res = 8'h00;
      asb_pkg::bit_clear_op: res = f_val & ~bit_mask;
      asb_pkg::bit_set_op: res = f_val | bit_mask;
      asb_pkg::nibble_exchange_op: res = {f_val[3:0], f_val[7:4]};
      asb_pkg::store_acc_op: res = w_val;
      asb_pkg::and_literal_op: res = w_val & lit;
      default: res = f_val;
    endcase
  end

  // flag values and the flags each operation owns
  assign z = res == 8'h00;
  assign dc = nib[4];
  assign c = is_arith ? sum[8] : (op == asb_pkg::rotate_right_op ? f_val[0] : f_val[7]);
  assign upd_z = is_arith || op == asb_pkg::clear_reg_op || op == asb_pkg::and_literal_op;
  assign upd_dc = is_arith;
  assign upd_c = is_arith || is_rot;
endmodule

// ---- logic/asb_prog_counter.sv ----
// program counter with wraparound and fixed reset and interrupt vectors
`timescale 1ns/1ps
`include "asb_consts.svh"
module asb_prog_counter #(
  parameter int PC_W = `ASB_PC_W,
  parameter int PROG_WORDS = `ASB_PROG_WORDS
) (
  // clock and reset
  input logic clk,
  input logic rstn,
  // sequencing controls
  input logic step,
  input logic jump,
  input logic [PC_W-1:0] target,
  input logic irq_take,
  // fetch address
  output logic [PC_W-1:0] pc
);
  localparam logic [PC_W-1:0] WRAP_MASK = PC_W'(PROG_WORDS - 1);
  localparam logic [PC_W-1:0] RST_ADDR = PC_W'(`ASB_RESET_VEC);
  localparam logic [PC_W-1:0] IRQ_ADDR = PC_W'(`ASB_IRQ_VEC);
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_raw;
  logic [PC_W-1:0] pc_nxt;

  // vector beats jump, jump beats step; high bits fold back into memory
  assign pc_raw = irq_take ? IRQ_ADDR : jump ? target : step ? pc_r + PC_W'(1) : pc_r;
  assign pc_nxt = pc_raw & WRAP_MASK;
  assign pc = pc_r;

  // counter register, starts at the reset vector
  always_ff @(posedge clk)
  begin
    if (!rstn)
      pc_r <= RST_ADDR;
    else
      pc_r <= pc_nxt;
  end

  a_pc_irq_vec: assert property (@(posedge clk) disable iff (!rstn)
    irq_take |=> pc_r == (IRQ_ADDR & WRAP_MASK))
    else $error("interrupt did not vector to the interrupt address");
  a_pc_wrap_step: assert property (@(posedge clk) disable iff (!rstn)
    step && !jump && !irq_take |=> pc_r == (($past(pc_r) + PC_W'(1)) & WRAP_MASK))
    else $error("step did not advance and wrap");
  a_pc_reset_start: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> pc_r == RST_ADDR)
    else $error("fetch did not start at the reset address");
  a_pc_in_range: assert property (@(posedge clk) disable iff (!rstn)
    (pc_r & ~WRAP_MASK) == '0)
    else $error("fetch address outside implemented memory");
endmodule

// ---- logic/asb_status_core.sv ----
// status register, bank select and program counter reached over axi4-lite
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "asb_consts.svh"

// Notes on behaviour
// - program counter is 13 bits, addressing up to 8K words.
// - fetch addresses above implemented memory wrap back into range.
// - fetch starts at word 0000h after reset; interrupts vector to 0004h.
// - any operation may name the status register as its destination.
// - zero, nibble carry and carry written by flag-owning operations come from result.
// - watchdog expiry and sleep entered flags are never changed by writes.
// - clearing status zeroes the bank bits, sets zero, keeps other bits.
// - bit clear, bit set, nibble exchange and store leave the flags alone unless status is their destination.
// - indirect bank bit selects 100h-1FFh when set, 00h-FFh when clear.
// - two direct bank bits select a 128-byte bank at 00h, 80h, 100h, 180h.
// - zero flag is set for a zero result and cleared otherwise.
// - nibble carry records carry out of bit 3; inverted borrow on subtract.
// - carry records carry out of bit 7; inverted borrow on subtract.
// - subtraction adds the two's complement; both carries come from that sum.
// - rotates load carry from the low or high source bit.
module asb_status_core #(
  parameter int PC_W = `ASB_PC_W,
  parameter int PROG_WORDS = `ASB_PROG_WORDS
) (
  // clock and reset
  input logic clk,
  input logic rstn,
  // axi4-lite write address
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // axi4-lite read address
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // core events
  input logic wdog_expire,
  // core outputs
  output logic [PC_W-1:0] fetch_addr,
  output logic [8:0] direct_bank_base,
  output logic [8:0] indirect_bank_base
);
  // write channel state
  logic aw_hold_r;
  logic w_hold_r;
  logic bvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  // read channel state
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // architectural state
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [7:0] freg_r;
  logic [7:0] freg_nxt;
  // decode and operation wires
  logic wr_fire;
  logic sel_status;
  logic sel_op;
  logic sel_acc;
  logic sel_freg;
  logic sel_pc;
  logic sel_bank;
  logic wr_known;
  logic st_wr;
  logic op_go;
  logic dest_file;
  logic fsel_status;
  logic st_dest;
  logic writes_acc;
  logic [7:0] lit;
  logic [7:0] f_val;
  asb_pkg::asb_op_e op;
  logic [7:0] alu_res;
  logic alu_z;
  logic alu_dc;
  logic alu_c;
  logic upd_z;
  logic upd_dc;
  logic upd_c;
  logic pc_step;
  logic pc_jump;
  logic pc_irq;
  logic rd_known;
  logic [31:0] rd_word;

  // write handshake: address and data are held until both are present
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // write address decode on the held address
  assign sel_status = awaddr_r == `ASB_OFF_STATUS;
  assign sel_op = awaddr_r == `ASB_OFF_OP;
  assign sel_acc = awaddr_r == `ASB_OFF_ACC;
  assign sel_freg = awaddr_r == `ASB_OFF_FREG;
  assign sel_pc = awaddr_r == `ASB_OFF_PC;
  assign sel_bank = awaddr_r == `ASB_OFF_BANK;
  assign wr_known = sel_status || sel_op || sel_acc || sel_freg || sel_pc || sel_bank;

  // write channel registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_hold_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_hold_r <= 1'b0;
    end
  end

  // write response, unmapped offsets answer with slave error
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `ASB_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_known ? `ASB_RESP_OKAY : `ASB_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // operation word fields
  assign op = asb_pkg::asb_op_e'(wdata_r[3:0]);
  assign dest_file = wdata_r[`ASB_OPF_DEST];
  assign fsel_status = wdata_r[`ASB_OPF_FSTAT];
  assign lit = wdata_r[`ASB_OPF_LIT_LSB +: 8];
  assign op_go = wr_fire && sel_op && wstrb_r[0];
  assign st_wr = wr_fire && sel_status && wstrb_r[0];
  assign st_dest = dest_file && fsel_status;
  assign f_val = fsel_status ? status_r : freg_r;
  assign writes_acc = op != asb_pkg::nop_op && op != asb_pkg::wdog_clear_op
    && op != asb_pkg::sleep_op;

  // arithmetic unit
  asb_flag_alu u_alu (
    .op(op),
    .f_val(f_val),
    .w_val(acc_r),
    .lit(lit),
    .c_in(status_r[`ASB_B_C]),
    .res(alu_res),
    .z(alu_z),
    .dc(alu_dc),
    .c(alu_c),
    .upd_z(upd_z),
    .upd_dc(upd_dc),
    .upd_c(upd_c)
  );

  // next status: masked writes, flags from the unit, reset cause flags
  always_comb
  begin
    status_nxt = status_r;
    if (st_wr)
      status_nxt = (status_r & ~`ASB_WR_MASK) | (wdata_r[7:0] & `ASB_WR_MASK);
    if (op_go)
    begin
      if (st_dest && op == asb_pkg::clear_reg_op)
        status_nxt = (status_r & ~`ASB_CLR_MASK) | (alu_res & `ASB_CLR_MASK);
      else if (st_dest)
        status_nxt = (status_r & ~`ASB_WR_MASK) | (alu_res & `ASB_WR_MASK);
      if (upd_z)
        status_nxt[`ASB_B_Z] = alu_z;
      if (upd_dc)
        status_nxt[`ASB_B_DC] = alu_dc;
      if (upd_c)
        status_nxt[`ASB_B_C] = alu_c;
      if (op == asb_pkg::wdog_clear_op)
      begin
        status_nxt[`ASB_B_TO] = 1'b1;
        status_nxt[`ASB_B_PD] = 1'b1;
      end
      if (op == asb_pkg::sleep_op)
      begin
        status_nxt[`ASB_B_TO] = 1'b1;
        status_nxt[`ASB_B_PD] = 1'b0;
      end
    end
    if (wdog_expire)
      status_nxt[`ASB_B_TO] = 1'b0;
  end

  // next accumulator and file register
  assign acc_nxt = (wr_fire && sel_acc && wstrb_r[0]) ? wdata_r[7:0]
    : (op_go && !dest_file && writes_acc) ? alu_res : acc_r;
  assign freg_nxt = (wr_fire && sel_freg && wstrb_r[0]) ? wdata_r[7:0]
    : (op_go && dest_file && !fsel_status && writes_acc) ? alu_res : freg_r;

  // architectural registers, power-up sets both reset cause flags
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      status_r <= `ASB_STATUS_RST;
      acc_r <= 8'h00;
      freg_r <= 8'h00;
    end
    else
    begin
      status_r <= status_nxt;
      acc_r <= acc_nxt;
      freg_r <= freg_nxt;
    end
  end

  // bank bases for direct and indirect data addressing
  assign direct_bank_base = {status_r[`ASB_B_RP1], status_r[`ASB_B_RP0], 7'h00};
  assign indirect_bank_base = {status_r[`ASB_B_IRP], 8'h00};

  // program counter controls; each executed operation advances fetch
  assign pc_jump = wr_fire && sel_pc && wstrb_r[2] && wdata_r[`ASB_PCF_JUMP];
  assign pc_irq = wr_fire && sel_pc && wstrb_r[2] && wdata_r[`ASB_PCF_IRQ];
  assign pc_step = op_go || (wr_fire && sel_pc && wstrb_r[2] && wdata_r[`ASB_PCF_STEP]);

  asb_prog_counter #(
    .PC_W(PC_W),
    .PROG_WORDS(PROG_WORDS)
  ) u_pc (
    .clk(clk),
    .rstn(rstn),
    .step(pc_step),
    .jump(pc_jump),
    .target(wdata_r[PC_W-1:0]),
    .irq_take(pc_irq),
    .pc(fetch_addr)
  );

  // read decode and data select
  assign rd_known = s_axi_araddr == `ASB_OFF_STATUS || s_axi_araddr == `ASB_OFF_OP
    || s_axi_araddr == `ASB_OFF_ACC || s_axi_araddr == `ASB_OFF_FREG
    || s_axi_araddr == `ASB_OFF_PC || s_axi_araddr == `ASB_OFF_BANK;
  assign rd_word = (s_axi_araddr == `ASB_OFF_STATUS) ? {24'h000000, status_r}
    : (s_axi_araddr == `ASB_OFF_ACC) ? {24'h000000, acc_r}
    : (s_axi_araddr == `ASB_OFF_FREG) ? {24'h000000, freg_r}
    : (s_axi_araddr == `ASB_OFF_PC) ? 32'(fetch_addr)
    : (s_axi_araddr == `ASB_OFF_BANK)
      ? {7'h00, indirect_bank_base, 7'h00, direct_bank_base}
    : 32'h00000000;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // read channel registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `ASB_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_known ? `ASB_RESP_OKAY : `ASB_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // checks on the status behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_status_ro_bits: assert property (
    st_wr && !wdog_expire |=> status_r[4:3] == $past(status_r[4:3]))
    else $error("bus write changed a read-only status bit");
  a_clear_status: assert property (
    op_go && st_dest && op == asb_pkg::clear_reg_op && !wdog_expire
    |=> status_r[7:5] == 3'b000 && status_r[2] && status_r[4:3] == $past(status_r[4:3])
      && status_r[1:0] == $past(status_r[1:0]))
    else $error("clear of status gave wrong bits");
  a_flag_over_write: assert property (
    op_go && st_dest && upd_z |=> status_r[2] == $past(alu_z))
    else $error("written zero bit overrode the result flag");
  a_bitop_keeps_flags: assert property (
    op_go && (op == asb_pkg::bit_clear_op || op == asb_pkg::bit_set_op
      || op == asb_pkg::nibble_exchange_op || op == asb_pkg::store_acc_op)
    |=> status_r[2:0] == ($past(st_dest) ? $past(alu_res[2:0]) : $past(status_r[2:0])))
    else $error("flag changed by a flag-neutral operation");
  a_sub_borrow: assert property (
    op_go && !st_dest && op == asb_pkg::reg_minus_acc_op
    |=> status_r[0] == ($past(f_val) >= $past(acc_r))
      && ($past(dest_file) || acc_r == 8'($past(f_val) - $past(acc_r))))
    else $error("subtract carry is not the inverted borrow");
  a_rotate_carry: assert property (
    op_go && !st_dest && op == asb_pkg::rotate_right_op |=> status_r[0] == $past(f_val[0]))
    else $error("rotate right did not load carry from bit 0");
  a_sleep_flags: assert property (
    op_go && op == asb_pkg::sleep_op && !wdog_expire |=> status_r[4:3] == 2'b10)
    else $error("sleep left the wrong reset cause flags");
  a_bank_follows: assert property (
    st_wr |=> direct_bank_base == {$past(wdata_r[6:5]), 7'h00}
      && indirect_bank_base == {$past(wdata_r[7]), 8'h00})
    else $error("bank base does not follow written bank bits");
endmodule

// ---- sim/asb_status_core_tb.sv ----
// self-checking bench for the status core, driven over axi4-lite
`timescale 1ns/1ps
`include "asb_consts.svh"
module testbench;
  localparam int PW = 2048;
  localparam logic [1:0] OK = `ASB_RESP_OKAY;
  localparam logic [1:0] SE = `ASB_RESP_SLVERR;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic wdog_expire = 1'b0;
  logic [12:0] fetch_addr;
  logic [8:0] direct_bank_base;
  logic [8:0] indirect_bank_base;
  int miscompares = 0;
  int check_count = 0;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  asb_pkg::asb_op_e ops[6] = '{asb_pkg::add_acc_to_reg_op, asb_pkg::add_literal_op,
    asb_pkg::literal_minus_acc_op, asb_pkg::reg_minus_acc_op, asb_pkg::rotate_right_op,
    asb_pkg::rotate_left_op};

  // clock at 100 MHz
  always #5 clk = ~clk;

  asb_status_core #(.PC_W(13), .PROG_WORDS(PW)) dut_u (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wdog_expire(wdog_expire),
    .fetch_addr(fetch_addr), .direct_bank_base(direct_bank_base),
    .indirect_bank_base(indirect_bank_base)
  );

  // closing report and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // mismatch bookkeeping
  task automatic fail(input string msg);
    miscompares++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  // direct comparison of an output port
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    logic ah;
    logic wh;
    logic bh;
    exp_b.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      @(posedge clk);
      if (ah)
        s_axi_awvalid <= 1'b0;
      if (wh)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!bh && n < 50);
    s_axi_bready <= 1'b0;
    @(posedge clk);
    if (!bh)
    begin
      fail("write response timeout");
      stop_test();
    end
  endtask

  // read: address held until taken, rready held until data seen
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ah;
    logic rh;
    exp_r.push_back({er, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      @(posedge clk);
      if (ah)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!rh && n < 50);
    s_axi_rready <= 1'b0;
    @(posedge clk);
    if (!rh)
    begin
      fail("read data timeout");
      stop_test();
    end
  endtask

  // monitor: each response taken off the bus is matched with the oldest note
  always @(posedge clk)
  begin
    if (s_axi_bvalid && s_axi_bready)
    begin
      check_count++;
      if (exp_b.size() == 0)
        fail("unexpected write response");
      else if (s_axi_bresp !== exp_b.pop_front())
        fail($sformatf("bresp %h", s_axi_bresp));
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      check_count++;
      if (exp_r.size() == 0)
        fail("unexpected read data");
      else if ({s_axi_rresp, s_axi_rdata} !== exp_r.pop_front())
        fail($sformatf("read %h resp %h", s_axi_rdata, s_axi_rresp));
    end
  end

  // expected result and flags {res, z, dc, c} worked out independently
  function automatic logic [10:0] alu_exp(input asb_pkg::asb_op_e op, input logic [7:0] f,
                                          input logic [7:0] w, input logic ci);
    logic sub;
    logic [7:0] a;
    logic [7:0] b;
    logic [8:0] s;
    logic [4:0] n;
    sub = (op == asb_pkg::literal_minus_acc_op) || (op == asb_pkg::reg_minus_acc_op);
    a = f;
    b = sub ? ~w : w;
    s = {1'b0, a} + {1'b0, b} + {8'h00, sub};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, sub};
    if (op == asb_pkg::rotate_right_op)
      return {ci, f[7:1], 2'b00, f[0]};
    if (op == asb_pkg::rotate_left_op)
      return {f[6:0], ci, 2'b00, f[7]};
    return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
  endfunction

  // main sequence
  initial
  begin
    logic [31:0] v;
    logic [7:0] w;
    logic [7:0] f;
    logic [10:0] e;
    asb_pkg::asb_op_e op;
    v = $urandom(32);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`ASB_OFF_STATUS, 32'h0000_0018, OK);
    rd(`ASB_OFF_PC, 32'h0000_0000, OK);
    chk(32'(fetch_addr), 32'h0000_0000, "fetch after reset");
    wr(`ASB_OFF_STATUS, 32'h0000_0000, 4'hF, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_0018, OK);
    wr(`ASB_OFF_STATUS, 32'h0000_00E7, 4'h0, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_0018, OK);
    for (int i = 0; i < 8; i++)
    begin
      wr(`ASB_OFF_STATUS, {24'h0, i[2:0], 5'h00}, 4'hF, OK);
      rd(`ASB_OFF_BANK, {7'h0, i[2], 8'h00, 7'h0, i[1:0], 7'h00}, OK);
      chk(32'(direct_bank_base), {23'h0, i[1:0], 7'h00}, "direct base");
      chk(32'(indirect_bank_base), {23'h0, i[2], 8'h00}, "indirect base");
    end
    wr(`ASB_OFF_BANK, 32'h0000_0000, 4'hF, OK);
    rd(`ASB_OFF_BANK, 32'h0100_0180, OK);
    wr(`ASB_OFF_STATUS, 32'h0000_00FF, 4'hF, OK);
    wr(`ASB_OFF_OP, {26'h0, 2'b11, 4'(asb_pkg::clear_reg_op)}, 4'hF, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_001F, OK);
    wr(`ASB_OFF_STATUS, 32'h0000_0000, 4'hF, OK);
    wr(`ASB_OFF_OP, {16'h0, 8'h00, 4'h3, 4'(asb_pkg::bit_set_op)}, 4'hF, OK);
    wr(`ASB_OFF_OP, {16'h0, 8'h02, 4'h3, 4'(asb_pkg::bit_set_op)}, 4'hF, OK);
    wr(`ASB_OFF_OP, {16'h0, 8'h00, 4'h3, 4'(asb_pkg::bit_clear_op)}, 4'hF, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_001C, OK);
    wr(`ASB_OFF_ACC, 32'h0000_00A5, 4'hF, OK);
    wr(`ASB_OFF_OP, {26'h0, 2'b11, 4'(asb_pkg::store_acc_op)}, 4'hF, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_00BD, OK);
    wr(`ASB_OFF_OP, {26'h0, 2'b11, 4'(asb_pkg::nibble_exchange_op)}, 4'hF, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_00DB, OK);
    // arithmetic flags: fixed corner operands first, then random ones
    for (int k = 0; k < 30; k++)
    begin
      v = $urandom;
      op = ops[k % 6];
      w = (k < 6) ? 8'hFF : v[7:0];
      f = (k < 6) ? 8'h01 : ((k < 12) ? w : v[15:8]);
      e = alu_exp(op, f, w, v[16]);
      wr(`ASB_OFF_STATUS, {31'h0, v[16]}, 4'hF, OK);
      wr(`ASB_OFF_ACC, {24'h0, w}, 4'hF, OK);
      wr(`ASB_OFF_FREG, {24'h0, f}, 4'hF, OK);
      wr(`ASB_OFF_OP, {16'h0, f, 4'h0, 4'(op)}, 4'hF, OK);
      rd(`ASB_OFF_ACC, {24'h0, e[10:3]}, OK);
      rd(`ASB_OFF_STATUS, {24'h0, 5'h03, e[2:0]}, OK);
    end
    // zero accumulator so the literal add gives a zero result with no carries
    wr(`ASB_OFF_ACC, 32'h0000_0000, 4'hF, OK);
    wr(`ASB_OFF_OP, {26'h0, 2'b11, 4'(asb_pkg::add_literal_op)}, 4'hF, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_001C, OK);
    // watchdog and sleep flags
    @(posedge clk);
    wdog_expire <= 1'b1;
    @(posedge clk);
    wdog_expire <= 1'b0;
    rd(`ASB_OFF_STATUS, 32'h0000_000C, OK);
    wr(`ASB_OFF_OP, {28'h0, 4'(asb_pkg::sleep_op)}, 4'hF, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_0014, OK);
    wr(`ASB_OFF_OP, {28'h0, 4'(asb_pkg::wdog_clear_op)}, 4'hF, OK);
    rd(`ASB_OFF_STATUS, 32'h0000_001C, OK);
    // program counter: wrap, step, vector priority
    wr(`ASB_OFF_PC, 32'h0001_1FFE, 4'hF, OK);
    rd(`ASB_OFF_PC, 32'h0000_07FE, OK);
    wr(`ASB_OFF_PC, 32'h0002_0000, 4'hF, OK);
    wr(`ASB_OFF_OP, {28'h0, 4'(asb_pkg::and_literal_op)}, 4'hF, OK);
    rd(`ASB_OFF_PC, 32'h0000_0000, OK);
    wr(`ASB_OFF_OP, {28'h0, 4'(asb_pkg::nop_op)}, 4'hF, OK);
    rd(`ASB_OFF_PC, 32'h0000_0001, OK);
    wr(`ASB_OFF_PC, 32'h0007_0123, 4'hF, OK);
    chk(32'(fetch_addr), 32'h0000_0004, "interrupt vector");
    // unmapped and misaligned places
    rd(8'h18, 32'h0000_0000, SE);
    rd(8'h02, 32'h0000_0000, SE);
    wr(8'h1C, 32'h0000_00FF, 4'hF, SE);
    rd(`ASB_OFF_STATUS, 32'h0000_001C, OK);
    // reset in mid-run restores the power-up values
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`ASB_OFF_STATUS, 32'h0000_0018, OK);
    chk(32'(fetch_addr), 32'h0000_0000, "fetch after second reset");
    repeat (2) @(posedge clk);
    if (exp_r.size() != 0 || exp_b.size() != 0)
      fail("responses missing");
    stop_test();
  end
endmodule
